/* File: hw/bpp_pkg.sv */
// Purpose: Shared constants and types for the bus port pin block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Printed offsets are indices; byte address is four times index
package bpp_pkg;
    // Operating modes
    typedef enum logic [2:0] {
        BPP_MODE_NORM_SINGLE,
        BPP_MODE_SPEC_SINGLE,
        BPP_MODE_NORM_EXP_NARROW,
        BPP_MODE_NORM_EXP_WIDE,
        BPP_MODE_SPEC_EXP_NARROW,
        BPP_MODE_SPEC_EXP_WIDE,
        BPP_MODE_PERIPH
    } bpp_mode_t;
    // Register indices
    localparam logic [7:0] BPP_IDX_LOW_DATA = 8'h01;
    localparam logic [7:0] BPP_IDX_LOW_DIR = 8'h03;
    localparam logic [7:0] BPP_IDX_CTL_DATA = 8'h08;
    localparam logic [7:0] BPP_IDX_CTL_DIR = 8'h09;
    localparam logic [7:0] BPP_IDX_CTL_ASSIGN = 8'h0a;
    localparam logic [7:0] BPP_IDX_PULLUP = 8'h0c;
    // Field positions in the assignment register
    localparam int BPP_ASG_NO_DBE = 7;
    localparam int BPP_ASG_CGM_TEST = 6;
    localparam int BPP_ASG_PIPE = 5;
    localparam int BPP_ASG_NO_BUS_E_CLOCK = 4;
    localparam int BPP_ASG_LSTR = 3;
    localparam int BPP_ASG_RDW = 2;
    localparam int BPP_ASG_CAL = 1;
    localparam int BPP_ASG_BUS_ENABLE_OR_INVERTED_CLOCK = 0;
    // Reset values
    localparam logic [7:0] BPP_ASG_RST_NORM_EXP = 8'h00;
    localparam logic [7:0] BPP_ASG_RST_SPECIAL = 8'h2c;
    localparam logic [7:0] BPP_ASG_RST_PERIPH = 8'hd0;
    localparam logic [7:0] BPP_ASG_RST_NORM_SINGLE = 8'h90;
    localparam logic [7:0] BPP_DIR_RST = 8'h00;
    localparam logic [7:0] BPP_DATA_RST = 8'h00;
    localparam logic [7:0] BPP_CTL_DIR_MASK = 8'hfc;
    localparam logic [7:0] BPP_PULLUP_PINS = 8'h8f;
    // Bus-control signals from the core
    typedef struct packed {
        logic data_bus_enable;
        logic bus_e_clock;
        logic pipe_status_hi;
        logic pipe_status_lo;
        logic low_byte_strobe;
        logic rw;
        logic clockgen_test_out;
        logic calibration;
    } bpp_ctl_sig_t;
    // Bus-side low port drive
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic data_phase;
        logic data_oe;
    } bpp_low_bus_t;
endpackage

/* File: hw/bpp_top.sv */
// Purpose: Pin logic for the low address/data port and bus-control port
// Assumes: Mode and emulate bit are stable inputs from the mode logic
// Notes: Unmapped or removed registers answer with pslverr
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module bpp_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bpp_pkg::bpp_mode_t mode,
    input wire logic emulate_control_port,
    input wire bpp_pkg::bpp_ctl_sig_t ctl_sig,
    input wire bpp_pkg::bpp_low_bus_t low_bus,
    input wire logic [7:0] low_port_in,
    output logic [7:0] low_port_out,
    output logic [7:0] low_port_oe,
    output logic [7:0] low_port_pullup,
    input wire logic [7:0] ctl_port_in,
    output logic [7:0] ctl_port_out,
    output logic [7:0] ctl_port_oe,
    output logic [7:0] ctl_port_pullup,
    output logic ext_access
);
    // Mode helpers
    function automatic logic is_single(input bpp_pkg::bpp_mode_t m);
        return (m == bpp_pkg::BPP_MODE_NORM_SINGLE) || (m == bpp_pkg::BPP_MODE_SPEC_SINGLE);
    endfunction
    function automatic logic is_narrow(input bpp_pkg::bpp_mode_t m);
        return (m == bpp_pkg::BPP_MODE_NORM_EXP_NARROW) || (m == bpp_pkg::BPP_MODE_SPEC_EXP_NARROW);
    endfunction
    // Assignment reset value per mode
    function automatic logic [7:0] asg_reset(input bpp_pkg::bpp_mode_t m);
        logic [7:0] v;
        v = bpp_pkg::BPP_ASG_RST_NORM_EXP;
        unique case (m)
            bpp_pkg::BPP_MODE_NORM_SINGLE: v = bpp_pkg::BPP_ASG_RST_NORM_SINGLE;
            bpp_pkg::BPP_MODE_SPEC_SINGLE: v = bpp_pkg::BPP_ASG_RST_SPECIAL;
            bpp_pkg::BPP_MODE_SPEC_EXP_NARROW, bpp_pkg::BPP_MODE_SPEC_EXP_WIDE: v = bpp_pkg::BPP_ASG_RST_SPECIAL;
            bpp_pkg::BPP_MODE_PERIPH: v = bpp_pkg::BPP_ASG_RST_PERIPH;
            default: v = bpp_pkg::BPP_ASG_RST_NORM_EXP;
        endcase
        return v;
    endfunction
    logic [7:0] low_data_reg; // Low port data
    logic [7:0] low_dir_reg; // Low port direction
    logic [7:0] ctl_data_reg; // Control port data
    logic [7:0] ctl_dir_reg; // Control port direction
    logic [7:0] asg_reg; // Assignment register
    logic pullup_reg; // Control port pull-up enable
    logic low_pullup_reg; // Low port pull-up enable
    logic asg_loaded_reg; // Mode value captured
    logic [7:0] low_in_s1_reg, low_in_s2_reg; // Low pin synchroniser
    logic [7:0] ctl_in_s1_reg, ctl_in_s2_reg; // Control pin synchroniser
    logic [7:0] ctl_alt; // Pins under alternate function
    logic [7:0] ctl_alt_out; // Alternate drive values
    logic [7:0] ctl_alt_oe; // Alternate drive enables
    logic single_chip, expanded, periph;
    logic low_mapped, ctl_mapped, asg_mapped;
    logic [7:0] idx;
    logic hit_ok, wr_en, rd_en;
    logic [7:0] rd_byte;

    assign single_chip = is_single(mode);
    assign periph = (mode == bpp_pkg::BPP_MODE_PERIPH);
    assign expanded = !single_chip && !periph;
    // low port registers only in single-chip
    assign low_mapped = single_chip;
    assign ctl_mapped = !periph && !(expanded && emulate_control_port);
    assign asg_mapped = !periph;

    // Word index decode
    assign idx = paddr[9:2];
    assign wr_en = psel && penable && pwrite && hit_ok;
    assign rd_en = psel && !pwrite;

    // Address hit check
    always_comb
    begin
        unique case (idx)
            bpp_pkg::BPP_IDX_LOW_DATA, bpp_pkg::BPP_IDX_LOW_DIR: hit_ok = low_mapped;
            bpp_pkg::BPP_IDX_CTL_DATA, bpp_pkg::BPP_IDX_CTL_DIR: hit_ok = ctl_mapped;
            bpp_pkg::BPP_IDX_CTL_ASSIGN: hit_ok = asg_mapped;
            bpp_pkg::BPP_IDX_PULLUP: hit_ok = 1'b1;
            default: hit_ok = 1'b0;
        endcase
        if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00)
        begin
            hit_ok = 1'b0;
        end
    end
    // Zero-wait slave
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_ok;
    assign ext_access = psel && penable && !hit_ok
        && ((expanded && (idx == bpp_pkg::BPP_IDX_LOW_DATA || idx == bpp_pkg::BPP_IDX_LOW_DIR))
        || (expanded && emulate_control_port
        && (idx == bpp_pkg::BPP_IDX_CTL_DATA || idx == bpp_pkg::BPP_IDX_CTL_DIR)));
    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_in_s1_reg <= 8'h00;
            low_in_s2_reg <= 8'h00;
            ctl_in_s1_reg <= 8'h00;
            ctl_in_s2_reg <= 8'h00;
        end
        else
        begin
            low_in_s1_reg <= low_port_in;
            low_in_s2_reg <= low_in_s1_reg;
            ctl_in_s1_reg <= ctl_port_in;
            ctl_in_s2_reg <= ctl_in_s1_reg;
        end
    end

    // Low port registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_data_reg <= bpp_pkg::BPP_DATA_RST;
            low_dir_reg <= bpp_pkg::BPP_DIR_RST;
        end
        else if (wr_en && idx == bpp_pkg::BPP_IDX_LOW_DATA)
        begin
            low_data_reg <= pwdata[7:0];
        end
        else if (wr_en && idx == bpp_pkg::BPP_IDX_LOW_DIR)
        begin
            low_dir_reg <= pwdata[7:0];
        end
    end

    // Control port data and direction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_data_reg <= bpp_pkg::BPP_DATA_RST;
            ctl_dir_reg <= bpp_pkg::BPP_DIR_RST;
        end
        else if (wr_en && idx == bpp_pkg::BPP_IDX_CTL_DATA)
        begin
            ctl_data_reg <= pwdata[7:0];
        end
        else if (wr_en && idx == bpp_pkg::BPP_IDX_CTL_DIR)
        begin
            ctl_dir_reg <= pwdata[7:0] & bpp_pkg::BPP_CTL_DIR_MASK;
        end
    end

    // Assignment register, loaded from mode after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            asg_reg <= bpp_pkg::BPP_ASG_RST_NORM_EXP;
            asg_loaded_reg <= 1'b0;
        end
        else if (!asg_loaded_reg)
        begin
            asg_reg <= asg_reset(mode);
            asg_loaded_reg <= 1'b1;
        end
        else if (wr_en && idx == bpp_pkg::BPP_IDX_CTL_ASSIGN)
        begin
            asg_reg <= pwdata[7:0];
        end
    end

    // Pull-up enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pullup_reg <= 1'b1;
            low_pullup_reg <= 1'b0;
        end
        else if (wr_en && idx == bpp_pkg::BPP_IDX_PULLUP)
        begin
            pullup_reg <= pwdata[4];
            low_pullup_reg <= pwdata[1];
        end
    end

    // Alternate function selection and drive
    always_comb
    begin
        ctl_alt = 8'h00;
        ctl_alt_out = 8'h00;
        ctl_alt_oe = 8'h00;
        // bit 7 bus enable, inverted clock or calibration
        if (expanded && !asg_reg[bpp_pkg::BPP_ASG_NO_DBE])
        begin
            ctl_alt[7] = 1'b1;
            ctl_alt_out[7] = asg_reg[bpp_pkg::BPP_ASG_BUS_ENABLE_OR_INVERTED_CLOCK] ? !ctl_sig.bus_e_clock : ctl_sig.data_bus_enable;
            ctl_alt_oe[7] = 1'b1;
        end
        else if (asg_reg[bpp_pkg::BPP_ASG_CAL] && (!expanded || asg_reg[bpp_pkg::BPP_ASG_NO_DBE]))
        begin
            ctl_alt[7] = 1'b1;
            ctl_alt_out[7] = ctl_sig.calibration;
            ctl_alt_oe[7] = 1'b1;
        end
        // bits 6 and 5 pipe status or test
        if (expanded && asg_reg[bpp_pkg::BPP_ASG_PIPE])
        begin
            ctl_alt[6] = 1'b1;
            ctl_alt[5] = 1'b1;
            ctl_alt_out[6] = ctl_sig.pipe_status_hi;
            ctl_alt_out[5] = ctl_sig.pipe_status_lo;
            ctl_alt_oe[6] = 1'b1;
            ctl_alt_oe[5] = 1'b1;
        end
        else if (asg_reg[bpp_pkg::BPP_ASG_CGM_TEST] && !single_chip
            && mode != bpp_pkg::BPP_MODE_NORM_EXP_NARROW && mode != bpp_pkg::BPP_MODE_NORM_EXP_WIDE)
        begin
            ctl_alt[6] = 1'b1;
            ctl_alt_out[6] = ctl_sig.clockgen_test_out;
            ctl_alt_oe[6] = 1'b1;
        end
        // bit 4 E clock, input in peripheral mode
        if (!asg_reg[bpp_pkg::BPP_ASG_NO_BUS_E_CLOCK])
        begin
            ctl_alt[4] = 1'b1;
            ctl_alt_out[4] = ctl_sig.bus_e_clock;
            ctl_alt_oe[4] = !periph;
        end
        // bit 3 low strobe, not in single or normal narrow
        if (asg_reg[bpp_pkg::BPP_ASG_LSTR] && !single_chip && mode != bpp_pkg::BPP_MODE_NORM_EXP_NARROW)
        begin
            ctl_alt[3] = 1'b1;
            ctl_alt_out[3] = ctl_sig.low_byte_strobe;
            ctl_alt_oe[3] = 1'b1;
        end
        // bit 2 read/write, not in single-chip
        if (asg_reg[bpp_pkg::BPP_ASG_RDW] && !single_chip)
        begin
            ctl_alt[2] = 1'b1;
            ctl_alt_out[2] = ctl_sig.rw;
            ctl_alt_oe[2] = 1'b1;
        end
    end

    // Control port pins
    always_comb
    begin
        ctl_port_out = (ctl_alt & ctl_alt_out) | (~ctl_alt & ctl_data_reg);
        ctl_port_oe = (ctl_alt & ctl_alt_oe) | (~ctl_alt & ctl_dir_reg);
        ctl_port_oe[1:0] = 2'b00;
        ctl_port_out[1:0] = 2'b00;
        ctl_port_pullup = {8{pullup_reg}} & bpp_pkg::BPP_PULLUP_PINS & ~ctl_port_oe;
    end

    // Low port pins
    always_comb
    begin
        if (single_chip)
        begin
            low_port_out = low_data_reg;
            low_port_oe = low_dir_reg;
        end
        else if (is_narrow(mode) && !periph)
        begin
            low_port_out = low_bus.addr;
            low_port_oe = 8'hff;
        end
        else
        begin
            low_port_out = low_bus.data_phase ? low_bus.data : low_bus.addr;
            low_port_oe = low_bus.data_phase ? {8{low_bus.data_oe}} : 8'hff;
        end
        low_port_pullup = {8{low_pullup_reg}} & ~low_port_oe;
    end

    // Read data mux
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (idx)
            bpp_pkg::BPP_IDX_LOW_DATA: rd_byte = (low_dir_reg & low_data_reg) | (~low_dir_reg & low_in_s2_reg);
            bpp_pkg::BPP_IDX_LOW_DIR: rd_byte = low_dir_reg;
            bpp_pkg::BPP_IDX_CTL_DATA: rd_byte = (ctl_port_oe & ctl_data_reg) | (~ctl_port_oe & ctl_in_s2_reg);
            bpp_pkg::BPP_IDX_CTL_DIR: rd_byte = ctl_dir_reg;
            bpp_pkg::BPP_IDX_CTL_ASSIGN: rd_byte = asg_reg;
            bpp_pkg::BPP_IDX_PULLUP: rd_byte = {3'b000, pullup_reg, 2'b00, low_pullup_reg, 1'b0};
            default: rd_byte = 8'h00;
        endcase
    end

    // Registered read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_en && !penable && hit_ok)
        begin
            prdata <= {24'h00_0000, rd_byte};
        end
        else if (rd_en && !penable)
        begin
            prdata <= 32'h0000_0000;
        end
    end

    // Direction bits of interrupt pins stay zero
    property p_irq_dir_zero;
        @(posedge pclk) disable iff (!presetn) ctl_dir_reg[1:0] == 2'b00;
    endproperty
    a_irq_dir_zero: assert property (p_irq_dir_zero) else $error("irq dir set");
    property p_irq_no_drive;
        @(posedge pclk) disable iff (!presetn) ctl_port_oe[1:0] == 2'b00;
    endproperty
    a_irq_no_drive: assert property (p_irq_no_drive) else $error("irq pin driven");
    property p_low_unmapped;
        @(posedge pclk) disable iff (!presetn) (psel && penable && !single_chip
            && idx == bpp_pkg::BPP_IDX_LOW_DIR) |-> pslverr && (ext_access == expanded);
    endproperty
    a_low_unmapped: assert property (p_low_unmapped) else $error("low reg mapped");
    property p_ctl_emulated;
        @(posedge pclk) disable iff (!presetn) (psel && penable && expanded && emulate_control_port
            && idx == bpp_pkg::BPP_IDX_CTL_DATA) |-> pslverr && ext_access;
    endproperty
    a_ctl_emulated: assert property (p_ctl_emulated) else $error("ctl data mapped");
    property p_periph_asg_hold;
        @(posedge pclk) disable iff (!presetn) (periph && asg_loaded_reg && $stable(mode)) |=> $stable(asg_reg);
    endproperty
    a_periph_asg_hold: assert property (p_periph_asg_hold) else $error("periph asg changed");
    property p_single_gpio;
        @(posedge pclk) disable iff (!presetn) single_chip |-> low_port_oe == low_dir_reg;
    endproperty
    a_single_gpio: assert property (p_single_gpio) else $error("low gpio dir");
    property p_low_write;
        @(posedge pclk) disable iff (!presetn) (wr_en && idx == bpp_pkg::BPP_IDX_LOW_DIR)
            |=> low_dir_reg == $past(pwdata[7:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low dir write lost");
    property p_pullup_input;
        @(posedge pclk) disable iff (!presetn) (ctl_port_pullup & ctl_port_oe) == 8'h00;
    endproperty
    a_pullup_input: assert property (p_pullup_input) else $error("pullup on output");
    property p_asg_load;
        @(posedge pclk) disable iff (!presetn) (presetn && !asg_loaded_reg
            && mode == bpp_pkg::BPP_MODE_NORM_SINGLE) |=> asg_reg == bpp_pkg::BPP_ASG_RST_NORM_SINGLE;
    endproperty
    a_asg_load: assert property (p_asg_load) else $error("single asg reset");
endmodule

/* File: tb/bpp_ext_model.sv */
// Purpose: Pin-level model of the parts on the external bus
// Assumes: Each wire resolves device drive, then external drive, then pull-up
// Notes: A wire nobody drives and nobody pulls toggles every cycle
`timescale 1ns/1ps
module bpp_ext_model (
    input wire logic pclk,
    input wire logic [7:0] low_port_out,
    input wire logic [7:0] low_port_oe,
    input wire logic [7:0] low_port_pullup,
    input wire logic [7:0] ctl_port_out,
    input wire logic [7:0] ctl_port_oe,
    input wire logic [7:0] ctl_port_pullup,
    input wire logic [7:0] low_drive_val,
    input wire logic [7:0] low_drive_en,
    input wire logic [7:0] ctl_drive_val,
    input wire logic [7:0] ctl_drive_en,
    output logic [7:0] low_port_in,
    output logic [7:0] ctl_port_in
);
    // Changing level for floating wires, so no stale value can pass
    logic [7:0] float_reg = 8'h55;
    // Flip floating pattern each cycle
    always_ff @(posedge pclk)
    begin
        float_reg <= ~float_reg;
    end
    // Resolved low port wires
    assign low_port_in = (low_port_oe & low_port_out) | (~low_port_oe & low_drive_en & low_drive_val)
        | (~low_port_oe & ~low_drive_en & (low_port_pullup | float_reg));
    // Resolved control port wires
    assign ctl_port_in = (ctl_port_oe & ctl_port_out) | (~ctl_port_oe & ctl_drive_en & ctl_drive_val)
        | (~ctl_port_oe & ~ctl_drive_en & (ctl_port_pullup | float_reg));
endmodule

/* File: tb/bpp_top_tb.sv */
// Purpose: Self-checking bench for the bus port pin block
// Assumes: Zero-wait APB slave, byte registers in the low lane
// Notes: Mode changes only while reset is held
`timescale 1ns/1ps
module bpp_top_tb;
    logic pclk = 1'b0; // Bus clock
    logic presetn = 1'b0; // Async reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB controls
    logic [11:0] paddr = 12'h000; // APB address
    logic [31:0] pwdata = 32'h0, prdata; // APB data
    logic pready, pslverr, ext_access; // Answers
    bpp_pkg::bpp_mode_t mode = bpp_pkg::BPP_MODE_NORM_SINGLE; // Operating mode
    logic emulate_control_port = 1'b0; // Port emulation
    bpp_pkg::bpp_ctl_sig_t ctl_sig = 8'hc6; // Enable, clock, rw, test high
    bpp_pkg::bpp_low_bus_t low_bus = {8'h3c, 8'hc3, 1'b1, 1'b1}; // Core bus drive
    logic [7:0] low_port_in, low_port_out, low_port_oe, low_port_pullup; // Low pins
    logic [7:0] ctl_port_in, ctl_port_out, ctl_port_oe, ctl_port_pullup; // Control pins
    logic [7:0] ext_ctl_val = 8'h01; // External level on interrupt pins
    int fail_count = 0, checked = 0; // Tallies
    logic [31:0] rd; // Last read data
    logic err, xa; // Last error and external flag
    // Free-running clock
    initial forever #25 pclk = ~pclk;
    bpp_top bpp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
        .emulate_control_port(emulate_control_port), .ctl_sig(ctl_sig), .low_bus(low_bus),
        .low_port_in(low_port_in), .low_port_out(low_port_out), .low_port_oe(low_port_oe),
        .low_port_pullup(low_port_pullup), .ctl_port_in(ctl_port_in), .ctl_port_out(ctl_port_out),
        .ctl_port_oe(ctl_port_oe), .ctl_port_pullup(ctl_port_pullup), .ext_access(ext_access));
    bpp_ext_model bpp_ext_model_inst (.pclk(pclk), .low_port_out(low_port_out), .low_port_oe(low_port_oe),
        .low_port_pullup(low_port_pullup), .ctl_port_out(ctl_port_out), .ctl_port_oe(ctl_port_oe),
        .ctl_port_pullup(ctl_port_pullup), .low_drive_val(8'h0c), .low_drive_en(8'hff),
        .ctl_drive_val(ext_ctl_val), .ctl_drive_en(8'h03), .low_port_in(low_port_in), .ctl_port_in(ctl_port_in));
    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        xa = ext_access;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read with data and error expectations
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic exp_err);
        apb(1'b0, a, 8'h00);
        chk("read data", {24'h0, exp}, rd);
        chk("read error", {31'h0, exp_err}, {31'h0, err});
    endtask
    // Reset in a given mode
    task automatic do_reset(input bpp_pkg::bpp_mode_t m);
        @(posedge pclk);
        presetn <= 1'b0;
        mode <= m;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask
    // Counts, verdict, end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        give_verdict();
    end
    // Main sequence
    initial
    begin
        logic [7:0] asg_exp[7];
        logic low_rm[7];
        asg_exp = '{8'h90, 8'h2c, 8'h00, 8'h00, 8'h2c, 8'h2c, 8'h00};
        low_rm = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
        // Every mode: register presence, and assignment reset value outside peripheral mode
        for (int i = 0; i < 7; i++)
        begin
            do_reset(bpp_pkg::bpp_mode_t'(i));
            rd_chk(12'h028, asg_exp[i], i == 6);
            rd_chk(12'h004, low_rm[i] ? 8'h00 : 8'h0c, low_rm[i]);
            apb(1'b0, 12'h020, 8'h00);
            chk("control data removed", {31'h0, i == 6}, {31'h0, err});
            if (i == 2)
                chk("narrow address", 8'h3c, low_port_out);
            if (i == 6)
            begin
                apb(1'b1, 12'h028, 8'h00);
                chk("test pin", 2'b11, {ctl_port_oe[6], ctl_port_out[6]});
            end
            $display("test mode %0d done", i);
        end
        // Normal single chip: both ports as general-purpose pins
        do_reset(bpp_pkg::BPP_MODE_NORM_SINGLE);
        rd_chk(12'h00c, 8'h00, 1'b0);
        chk("low oe reset", 8'h00, low_port_oe);
        chk("control pull-ups", 8'h8f, ctl_port_pullup);
        apb(1'b1, 12'h00c, 8'hf0);
        apb(1'b1, 12'h004, 8'ha5);
        apb(1'b1, 12'h024, 8'hff);
        apb(1'b1, 12'h020, 8'h5a);
        repeat (3) @(posedge pclk);
        chk("low oe", 8'hf0, low_port_oe);
        chk("low out", 8'ha0, low_port_out & 8'hf0);
        rd_chk(12'h004, 8'hac, 1'b0);
        rd_chk(12'h024, 8'hfc, 1'b0);
        chk("control oe", 8'hfc, ctl_port_oe);
        chk("control pull-ups out", 8'h03, ctl_port_pullup);
        rd_chk(12'h020, 8'h59, 1'b0);
        ext_ctl_val <= 8'h02;
        repeat (3) @(posedge pclk);
        rd_chk(12'h020, 8'h5a, 1'b0);
        // Low port pull-ups only on its input pins
        apb(1'b1, 12'h030, 8'h12);
        rd_chk(12'h030, 8'h12, 1'b0);
        chk("low pull-ups", 8'h0f, low_port_pullup);
        rd_chk(12'h03c, 8'h00, 1'b1);
        $display("test single chip done");
        // Normal expanded wide: bus lines, removed registers, emulation
        low_bus <= {8'h3c, 8'hc3, 1'b0, 1'b1};
        do_reset(bpp_pkg::BPP_MODE_NORM_EXP_WIDE);
        chk("address phase", 8'h3c, low_port_out);
        low_bus <= {8'h3c, 8'hc3, 1'b1, 1'b1};
        @(negedge pclk);
        chk("data phase", 8'hc3, low_port_out);
        chk("enable and clock", 4'hf, {ctl_port_oe[7], ctl_port_out[7], ctl_port_oe[4], ctl_port_out[4]});
        apb(1'b0, 12'h00c, 8'h00);
        chk("low dir external", 2'b11, {err, xa});
        // Strobe and rw enabled before the external control port read
        apb(1'b1, 12'h028, 8'h0c);
        rd_chk(12'h028, 8'h0c, 1'b0);
        chk("strobe and rw", 4'hd, {ctl_port_oe[3:2], ctl_port_out[3:2]});
        emulate_control_port <= 1'b1;
        apb(1'b0, 12'h020, 8'h00);
        chk("control data external", 2'b11, {err, xa});
        rd_chk(12'h024, 8'h00, 1'b1);
        $display("test expanded done");
        give_verdict();
    end
endmodule
